/* File: verilog/serializer_link_control_status.sv */
module serializer_link_control_status #(
  parameter int FILTER_LEN = serializer_link_pkg::FILTER_MIN_PCLK
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Pixel clock of the link
  input wire logic pix_clk,
  // Power-down pin
  input wire logic power_down_n,
  // Decoded control-bus transactions
  input serializer_link_pkg::reg_req_type reg_req,
  output serializer_link_pkg::reg_resp_type reg_resp,
  // Video from the receiver front end, pixel clock domain
  input serializer_link_pkg::video_in_type video_in,
  // Forward frames, one per port
  output logic [serializer_link_pkg::PORT_COUNT-1:0]
    [serializer_link_pkg::FRAME_W-1:0] fwd_frame,
  // Back-channel frames, pixel clock domain
  input serializer_link_pkg::bc_frame_type
    [serializer_link_pkg::PORT_COUNT-1:0] bc_frame,
  // Cable detect pins, high while the cable is sound
  input wire logic [serializer_link_pkg::PORT_COUNT-1:0] link_detect,
  // GPIO pins
  input wire logic [serializer_link_pkg::GPIO_COUNT-1:0] gpio_in,
  output logic [serializer_link_pkg::GPIO_COUNT-1:0] gpio_out,
  output logic [serializer_link_pkg::GPIO_COUNT-1:0] gpio_oe,
  // Interrupt pins
  output logic interrupt_out_n,
  output logic remote_interrupt_out_n
);
  import serializer_link_pkg::*;

  localparam int CNT_W = $clog2(FILTER_LEN);

  // Refuse filter lengths the counter cannot serve
  if (FILTER_LEN < 2 || FILTER_LEN > 16) begin : g_bad_filter_len
    $error("FILTER_LEN must lie between 2 and 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State types

  typedef struct packed {
    logic [7:0] filter_cfg;
    port_regs_type [PORT_COUNT-1:0] port_regs;
    logic [7:0] port_sel;
    logic [7:0] link_mode;
    logic [7:0] int_enable;
    logic [7:0] rem_route;
    logic int_pending;
    logic int_src_prev;
    logic pdn_meta;
    logic pdn_sync;
    logic [PORT_COUNT-1:0] det_meta;
    logic [PORT_COUNT-1:0] det_sync;
    logic [PORT_COUNT-1:0] rint_meta;
    logic [PORT_COUNT-1:0] rint_sync;
    logic tog_meta;
    logic tog_sync;
    logic tog_last;
    logic [RATE_CNT_W-1:0] rate_timer;
    logic [RATE_CNT_W-1:0] edge_count;
    logic rate_ok;
    logic active;
    pix_cfg_type cfg_shadow;
    logic cfg_tog;
    logic ack_meta;
    logic ack_sync;
    logic [7:0] rdata;
    logic rvalid;
    logic int_out_n;
    logic rem_out_n;
  } sys_state_type;

  typedef struct packed {
    logic active_meta;
    logic active_sync;
    logic cfg_tog_meta;
    logic cfg_tog_sync;
    logic cfg_tog_seen;
    pix_cfg_type cfg;
    logic [1:0] filt;
    logic [1:0][CNT_W-1:0] filt_cnt;
    logic [GPIO_COUNT-1:0] gpio_meta;
    logic [GPIO_COUNT-1:0] gpio_sync;
    logic [GPIO_COUNT-1:0] gpio_out;
    logic [GPIO_COUNT-1:0] gpio_oe;
    logic [PORT_COUNT-1:0] rint;
    logic [PORT_COUNT-1:0][GPIO_COUNT-1:0] bc_gpio;
    logic [FRAME_W-1:0] lfsr;
    logic [PORT_COUNT-1:0][FRAME_W-1:0] frame;
    logic pix_tog;
  } pix_state_type;

  sys_state_type sys;
  sys_state_type next_sys;
  pix_state_type pix;
  pix_state_type next_pix;

  ////////////////////////////////////////////////////////////////////////////
  // System domain: registers, status, interrupts

  // Next value of the system-domain state
  always_comb begin
    logic [PORT_COUNT-1:0] wmask;
    logic rport;
    logic accept;
    logic split_ok;
    logic [PORT_COUNT-1:0] act;
    logic combined;
    logic rem_lvl;
    logic int_src;
    logic [7:0] rd;
    pix_cfg_type live;
    link_mode_type mode;
    int pix_mhz;
    int lanes;
    sys_state_type keep;
    wmask = '0;
    rport = 1'b0;
    accept = 1'b0;
    split_ok = 1'b0;
    act = '0;
    combined = 1'b0;
    rem_lvl = 1'b0;
    int_src = 1'b0;
    rd = 8'h00;
    live = '0;
    mode = link_mode_type'(sys.link_mode[1:0]);
    pix_mhz = 0;
    lanes = 1;
    keep = '0;
    next_sys = sys;

    // Synchronisers for pins and pixel-domain levels
    next_sys.pdn_meta = power_down_n;
    next_sys.pdn_sync = sys.pdn_meta;
    next_sys.det_meta = link_detect;
    next_sys.det_sync = sys.det_meta;
    next_sys.rint_meta = pix.rint;
    next_sys.rint_sync = sys.rint_meta;
    next_sys.tog_meta = pix.pix_tog;
    next_sys.tog_sync = sys.tog_meta;
    next_sys.tog_last = sys.tog_sync;
    next_sys.ack_meta = pix.cfg_tog_seen;
    next_sys.ack_sync = sys.ack_meta;
    next_sys.active = 1'b1;

    // Port steering of duplicated registers
    split_ok = (mode == MODE_INDEPENDENT) || (mode == MODE_SPLITTER);
    accept = !reg_req.second_addr || sys.port_sel[SECOND_ADDR_EN_BIT];
    if (!split_ok) begin
      wmask = 2'b01;
      rport = 1'b0;
    end else if (sys.port_sel[SECOND_ADDR_EN_BIT]) begin
      wmask = reg_req.second_addr ? 2'b10 : 2'b01;
      rport = reg_req.second_addr;
    end else begin
      wmask = sys.port_sel[1:0];
      rport = sys.port_sel[SECOND_SEL_BIT];
    end

    // Read multiplexer, shared registers ignore the selects, except the link detect bit of status
    case (reg_req.addr)
      FILTER_CFG_ADDR: rd = sys.filter_cfg;
      STATUS_ADDR: begin
        rd[LINK_DETECT_BIT] = sys.det_sync[rport];
        rd[RATE_OK_BIT] = sys.rate_ok;
      end
      GPIO0_CFG_ADDR: rd = sys.port_regs[rport].gpio0;
      GPIO12_CFG_ADDR: rd = sys.port_regs[rport].gpio12;
      GPIO3_CFG_ADDR: rd = sys.port_regs[rport].gpio3;
      PORT_SEL_ADDR: rd = sys.port_sel;
      LINK_MODE_ADDR: rd = sys.link_mode;
      INT_ENABLE_ADDR: rd = sys.int_enable;
      INT_STATUS_ADDR: rd[INT_PENDING_BIT] = sys.int_pending;
      REM_ROUTE_ADDR: rd = sys.rem_route;
      default: rd = 8'h00;
    endcase
    next_sys.rvalid = reg_req.rd && accept;
    if (reg_req.rd && accept) begin
      next_sys.rdata = rd;
    end

    // Register writes
    if (reg_req.wr && accept) begin
      case (reg_req.addr)
        FILTER_CFG_ADDR: next_sys.filter_cfg = reg_req.wdata;
        GPIO0_CFG_ADDR, GPIO12_CFG_ADDR, GPIO3_CFG_ADDR: begin
          for (int p = 0; p < PORT_COUNT; p++) begin
            if (wmask[p]) begin
              if (reg_req.addr == GPIO0_CFG_ADDR) begin
                next_sys.port_regs[p].gpio0 = reg_req.wdata;
              end else if (reg_req.addr == GPIO12_CFG_ADDR) begin
                next_sys.port_regs[p].gpio12 = reg_req.wdata;
              end else begin
                next_sys.port_regs[p].gpio3 = reg_req.wdata;
              end
            end
          end
        end
        PORT_SEL_ADDR: begin
          next_sys.port_sel = 8'h00;
          next_sys.port_sel[FIRST_SEL_BIT] = reg_req.wdata[FIRST_SEL_BIT];
          next_sys.port_sel[SECOND_SEL_BIT] =
            reg_req.wdata[SECOND_SEL_BIT] &&
            (mode != MODE_FORCED_SINGLE);
          next_sys.port_sel[SECOND_ADDR_EN_BIT] =
            reg_req.wdata[SECOND_ADDR_EN_BIT];
        end
        LINK_MODE_ADDR: begin
          next_sys.link_mode = {6'h00, reg_req.wdata[1:0]};
          if (reg_req.wdata[1:0] == MODE_FORCED_SINGLE) begin
            next_sys.port_sel[SECOND_SEL_BIT] = 1'b0;
          end
        end
        INT_ENABLE_ADDR: next_sys.int_enable = reg_req.wdata;
        REM_ROUTE_ADDR: next_sys.rem_route = {4'h0, reg_req.wdata[3:0]};
        default: ;
      endcase
    end

    // Remote interrupt levels, valid only while the link is sound
    act = sys.rint_sync & sys.det_sync;
    combined = (mode == MODE_DUAL) ? act[0] : |act;
    if (sys.rem_route[3:0] == REM_ROUTE_SPLIT) begin
      rem_lvl = act[0];
      int_src = act[1];
    end else begin
      rem_lvl = combined;
      int_src = combined;
    end
    next_sys.rem_out_n = !rem_lvl;

    // Pending interrupt: read clears, a new event in the same cycle wins
    next_sys.int_src_prev = int_src;
    if (reg_req.rd && accept && reg_req.addr == INT_STATUS_ADDR) begin
      next_sys.int_pending = 1'b0;
    end
    if (sys.int_enable[REM_INT_EN_BIT] && sys.int_enable[GLOBAL_INT_EN_BIT]
        && int_src && !sys.int_src_prev) begin
      next_sys.int_pending = 1'b1;
    end
    next_sys.int_out_n = !next_sys.int_pending;

    // Pixel clock rate, measured over a fixed window
    if (sys.tog_sync != sys.tog_last) begin
      next_sys.edge_count = sys.edge_count + RATE_CNT_W'(1);
    end
    next_sys.rate_timer = sys.rate_timer + RATE_CNT_W'(1);
    if (sys.rate_timer == RATE_CNT_W'(RATE_WINDOW_CYCLES - 1)) begin
      pix_mhz = int'(sys.edge_count) * 1000 / RATE_WINDOW_NS;
      lanes = (mode == MODE_DUAL) ? 2 : 1;
      next_sys.rate_ok =
        (pix_mhz >= ((lanes == 2) ? PCLK_MIN_2L_MHZ : PCLK_MIN_1L_MHZ)) &&
        (pix_mhz <= ((lanes == 2) ? PCLK_MAX_2L_MHZ : PCLK_MAX_1L_MHZ)) &&
        (pix_mhz * FRAME_W <= LANE_MAX_MBPS * lanes) &&
        (pix_mhz * FRAME_W >= LANE_MIN_MBPS * lanes);
      next_sys.rate_timer = '0;
      next_sys.edge_count = '0;
    end

    // Configuration handed to the pixel domain by toggle handshake
    live.filter_en = sys.filter_cfg[FILTER_EN_BIT];
    for (int p = 0; p < PORT_COUNT; p++) begin
      live.gpio_cfg[p][0] = sys.port_regs[p].gpio0[3:0];
      live.gpio_cfg[p][1] = sys.port_regs[p].gpio12[3:0];
      live.gpio_cfg[p][2] = sys.port_regs[p].gpio12[7:4];
      live.gpio_cfg[p][3] = sys.port_regs[p].gpio3[3:0];
    end
    if (sys.ack_sync == sys.cfg_tog && live != sys.cfg_shadow) begin
      next_sys.cfg_shadow = live;
      next_sys.cfg_tog = !sys.cfg_tog;
    end

    // Power-down or reset returns every control register to default
    if (!rst_n || !sys.pdn_sync) begin
      keep = next_sys;
      next_sys = '0;
      next_sys.filter_cfg = FILTER_CFG_RESET;
      for (int p = 0; p < PORT_COUNT; p++) begin
        next_sys.port_regs[p].gpio0 = GPIO_CFG_RESET;
        next_sys.port_regs[p].gpio12 = GPIO_CFG_RESET;
        next_sys.port_regs[p].gpio3 = GPIO_CFG_RESET;
      end
      next_sys.port_sel = PORT_SEL_RESET;
      next_sys.link_mode = LINK_MODE_RESET;
      next_sys.int_enable = INT_ENABLE_RESET;
      next_sys.rem_route = REM_ROUTE_RESET;
      next_sys.int_out_n = 1'b1;
      next_sys.rem_out_n = 1'b1;
      if (rst_n) begin
        next_sys.pdn_meta = keep.pdn_meta;
        next_sys.pdn_sync = keep.pdn_sync;
      end
    end
  end

  // System-domain register
  always_ff @(posedge sys_clk) begin
    sys <= next_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel domain: filter, forward frames, back channel, GPIO

  // Next value of the pixel-domain state
  always_comb begin
    logic [1:0] raw;
    logic [GPIO_COUNT-1:0] fwd_gpio;
    pix_state_type keep;
    raw = {video_in.data_enable, video_in.horizontal_sync};
    fwd_gpio = '0;
    keep = '0;
    next_pix = pix;

    // Synchronisers for reset, config toggle and GPIO pins
    next_pix.active_meta = sys.active;
    next_pix.active_sync = pix.active_meta;
    next_pix.cfg_tog_meta = sys.cfg_tog;
    next_pix.cfg_tog_sync = pix.cfg_tog_meta;
    next_pix.cfg_tog_seen = pix.cfg_tog_sync;
    if (pix.cfg_tog_sync != pix.cfg_tog_seen) begin
      next_pix.cfg = sys.cfg_shadow;
    end
    next_pix.gpio_meta = gpio_in;
    next_pix.gpio_sync = pix.gpio_meta;
    next_pix.pix_tog = !pix.pix_tog;

    // Minimum pulse filter on horizontal sync and data enable
    for (int i = 0; i < 2; i++) begin
      if (!pix.cfg.filter_en) begin
        next_pix.filt[i] = raw[i];
        next_pix.filt_cnt[i] = '0;
      end else if (raw[i] == pix.filt[i]) begin
        next_pix.filt_cnt[i] = '0;
      end else if (pix.filt_cnt[i] == CNT_W'(FILTER_LEN - 1)) begin
        next_pix.filt[i] = raw[i];
        next_pix.filt_cnt[i] = '0;
      end else begin
        next_pix.filt_cnt[i] = pix.filt_cnt[i] + CNT_W'(1);
      end
    end

    // Back-channel frames are taken only with a good CRC
    for (int p = 0; p < PORT_COUNT; p++) begin
      if (bc_frame[p].valid && bc_frame[p].crc_ok) begin
        next_pix.bc_gpio[p] = bc_frame[p].gpio;
        next_pix.rint[p] = !bc_frame[p].remote_interrupt_in_n;
      end
    end

    // GPIO pins driven from port 0 back-channel data
    for (int g = 0; g < GPIO_COUNT; g++) begin
      next_pix.gpio_oe[g] =
        (pix.cfg.gpio_cfg[0][g] == GPIO_BC_OUTPUT);
      next_pix.gpio_out[g] = next_pix.gpio_oe[g] && pix.bc_gpio[0][g];
    end

    // Scrambler, one step per pixel clock
    next_pix.lfsr = {pix.lfsr[FRAME_W-2:0],
                     pix.lfsr[FRAME_W-1] ^ pix.lfsr[FRAME_W-3]};

    // Forward frame per port: payload XOR scrambler
    for (int p = 0; p < PORT_COUNT; p++) begin
      for (int g = 0; g < GPIO_COUNT; g++) begin
        fwd_gpio[g] = (pix.cfg.gpio_cfg[p][g] == GPIO_FWD_INPUT) &&
                      pix.gpio_sync[g];
      end
      next_pix.frame[p] = {video_in.rgb, pix.filt[0],
                           video_in.vertical_sync, pix.filt[1],
                           fwd_gpio, video_in.i2c, video_in.audio}
                          ^ pix.lfsr;
    end

    // Held in reset while the system side is down
    if (!pix.active_sync) begin
      keep = next_pix;
      next_pix = '0;
      next_pix.cfg.filter_en = FILTER_CFG_RESET[FILTER_EN_BIT];
      next_pix.lfsr = SCRAMBLE_SEED;
      next_pix.active_meta = keep.active_meta;
      next_pix.active_sync = keep.active_sync;
      next_pix.cfg_tog_meta = keep.cfg_tog_meta;
      next_pix.cfg_tog_sync = keep.cfg_tog_sync;
      next_pix.gpio_meta = keep.gpio_meta;
      next_pix.gpio_sync = keep.gpio_sync;
    end
  end

  // Pixel-domain register
  always_ff @(posedge pix_clk) begin
    pix <= next_pix;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // All outputs straight from flip-flops
  assign reg_resp.rvalid = sys.rvalid;
  assign reg_resp.rdata = sys.rdata;
  assign interrupt_out_n = sys.int_out_n;
  assign remote_interrupt_out_n = sys.rem_out_n;
  assign fwd_frame = pix.frame;
  assign gpio_out = pix.gpio_out;
  assign gpio_oe = pix.gpio_oe;

endmodule : serializer_link_control_status

/* File: verilog/serializer_link_pkg.sv */
package serializer_link_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] FILTER_CFG_ADDR = 8'h03;
  localparam logic [7:0] STATUS_ADDR = 8'h0c;
  localparam logic [7:0] GPIO0_CFG_ADDR = 8'h0d;
  localparam logic [7:0] GPIO12_CFG_ADDR = 8'h0e;
  localparam logic [7:0] GPIO3_CFG_ADDR = 8'h0f;
  localparam logic [7:0] PORT_SEL_ADDR = 8'h1e;
  localparam logic [7:0] LINK_MODE_ADDR = 8'h1f;
  localparam logic [7:0] INT_ENABLE_ADDR = 8'hc6;
  localparam logic [7:0] INT_STATUS_ADDR = 8'hc7;
  localparam logic [7:0] REM_ROUTE_ADDR = 8'hc8;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int FILTER_EN_BIT = 4;
  localparam int LINK_DETECT_BIT = 0;
  localparam int RATE_OK_BIT = 1;
  localparam int FIRST_SEL_BIT = 0;
  localparam int SECOND_SEL_BIT = 1;
  localparam int SECOND_ADDR_EN_BIT = 2;
  localparam int GLOBAL_INT_EN_BIT = 0;
  localparam int REM_INT_EN_BIT = 5;
  localparam int INT_PENDING_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [7:0] FILTER_CFG_RESET = 8'h10;
  localparam logic [7:0] GPIO_CFG_RESET = 8'h00;
  localparam logic [7:0] PORT_SEL_RESET = 8'h01;
  localparam logic [7:0] LINK_MODE_RESET = 8'h01;
  localparam logic [7:0] INT_ENABLE_RESET = 8'h00;
  localparam logic [7:0] REM_ROUTE_RESET = 8'h00;
  localparam logic [34:0] SCRAMBLE_SEED = 35'h4_5a5a_5a5a;

  ////////////////////////////////////////////////////////////////////////////
  // Codes and figures
  localparam logic [3:0] GPIO_FWD_INPUT = 4'h3;
  localparam logic [3:0] GPIO_BC_OUTPUT = 4'h5;
  localparam logic [3:0] REM_ROUTE_SPLIT = 4'h1;
  localparam int PORT_COUNT = 2;
  localparam int GPIO_COUNT = 4;
  localparam int FRAME_W = 35;
  localparam int FILTER_MIN_PCLK = 3;
  localparam int PCLK_MIN_1L_MHZ = 25;
  localparam int PCLK_MAX_1L_MHZ = 105;
  localparam int PCLK_MIN_2L_MHZ = 50;
  localparam int PCLK_MAX_2L_MHZ = 210;
  localparam int LANE_MAX_MBPS = 3675;
  localparam int LANE_MIN_MBPS = 875;
  localparam int SYS_CLK_MHZ = 250;
  localparam int RATE_WINDOW_NS = 1000;
  localparam int RATE_WINDOW_CYCLES = RATE_WINDOW_NS * SYS_CLK_MHZ / 1000;
  localparam int RATE_CNT_W = $clog2(RATE_WINDOW_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    MODE_FORCED_SINGLE = 2'b00,
    MODE_DUAL = 2'b01,
    MODE_INDEPENDENT = 2'b10,
    MODE_SPLITTER = 2'b11
  } link_mode_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic second_addr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic rvalid;
    logic [7:0] rdata;
  } reg_resp_type;

  typedef struct packed {
    logic [23:0] rgb;
    logic horizontal_sync;
    logic vertical_sync;
    logic data_enable;
    logic i2c;
    logic [2:0] audio;
  } video_in_type;

  typedef struct packed {
    logic valid;
    logic crc_ok;
    logic remote_interrupt_in_n;
    logic i2c;
    logic [3:0] gpio;
  } bc_frame_type;

  typedef struct packed {
    logic [7:0] gpio0;
    logic [7:0] gpio12;
    logic [7:0] gpio3;
  } port_regs_type;

  typedef struct packed {
    logic filter_en;
    logic [PORT_COUNT-1:0][GPIO_COUNT-1:0][3:0] gpio_cfg;
  } pix_cfg_type;

endpackage : serializer_link_pkg

/* File: tb/serializer_link_control_status_checker.sv */
module serializer_link_control_status_checker #(
  parameter int FILTER_LEN = serializer_link_pkg::FILTER_MIN_PCLK
) (
  // Clocks and resets
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pix_clk,
  input wire logic power_down_n,
  // Register bus
  input serializer_link_pkg::reg_req_type reg_req,
  input serializer_link_pkg::reg_resp_type reg_resp,
  // Link and pins
  input serializer_link_pkg::bc_frame_type [1:0] bc_frame,
  input wire logic [1:0] link_detect,
  input wire logic interrupt_out_n,
  input wire logic remote_interrupt_out_n
);
  import serializer_link_pkg::*;
  logic [3:0] pd_hist;
  logic off, rd_int, on0, quiet;
  // Mask the window around power-down
  always_ff @(posedge sys_clk) begin
    pd_hist <= rst_n ? {pd_hist[2:0], power_down_n} : 4'h0;
  end
  // Status reads and remote levels
  always_comb begin
    off = !rst_n || !(&pd_hist);
    rd_int = reg_req.rd && !reg_req.second_addr;
    rd_int = rd_int && reg_req.addr == INT_STATUS_ADDR;
    on0 = bc_frame[0].valid && bc_frame[0].crc_ok && link_detect[0];
    on0 = on0 && !bc_frame[0].remote_interrupt_in_n;
    quiet = 1'b1;
    for (int p = 0; p < 2; p++) begin
      quiet &= bc_frame[p].remote_interrupt_in_n || !link_detect[p];
    end
  end
  property p_rd_ans;
    @(posedge sys_clk) disable iff (off)
      reg_req.rd && !reg_req.second_addr |=> reg_resp.rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered");
  property p_rv_cause;
    @(posedge sys_clk) disable iff (off) reg_resp.rvalid |-> $past(reg_req.rd);
  endproperty
  a_rv_cause: assert property (p_rv_cause)
    else $error("answer without read");
  property p_rd_hold;
    @(posedge sys_clk) disable iff (off)
      !reg_resp.rvalid |-> $stable(reg_resp.rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved");
  property p_int_clr;
    @(posedge sys_clk) disable iff (off) rd_int |=> interrupt_out_n;
  endproperty
  a_int_clr: assert property (p_int_clr)
    else $error("interrupt not released");
  property p_int_hold;
    @(posedge sys_clk) disable iff (off)
      !interrupt_out_n && !rd_int |=> !interrupt_out_n;
  endproperty
  a_int_hold: assert property (p_int_hold)
    else $error("interrupt dropped early");
  property p_int_flag;
    @(posedge sys_clk) disable iff (off)
      rd_int && !interrupt_out_n |=> reg_resp.rdata[INT_PENDING_BIT];
  endproperty
  a_int_flag: assert property (p_int_flag)
    else $error("pending flag missing");
  property p_rem_low;
    @(posedge pix_clk) disable iff (off) on0 [*3] |-> !remote_interrupt_out_n;
  endproperty
  a_rem_low: assert property (p_rem_low)
    else $error("remote pin not low");
  property p_rem_high;
    @(posedge pix_clk) disable iff (off) quiet [*3] |-> remote_interrupt_out_n;
  endproperty
  a_rem_high: assert property (p_rem_high)
    else $error("remote pin not high");
  c_int_read: cover property (@(posedge sys_clk) rd_int && !interrupt_out_n);
  c_rem_low: cover property (@(posedge pix_clk) !remote_interrupt_out_n);
  c_second: cover property (@(posedge sys_clk) reg_req.second_addr);
endmodule : serializer_link_control_status_checker
//////////////////////////////////////////////////////////////////////////////
bind serializer_link_control_status serializer_link_control_status_checker
  #(.FILTER_LEN(FILTER_LEN)) i_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .pix_clk(pix_clk),
  .power_down_n(power_down_n), .reg_req(reg_req), .reg_resp(reg_resp),
  .bc_frame(bc_frame), .link_detect(link_detect),
  .interrupt_out_n(interrupt_out_n),
  .remote_interrupt_out_n(remote_interrupt_out_n)
);

/* File: tb/deser_model.sv */
module deser_model (
  // Pixel clock
  input wire logic pix_clk,
  // Commands from the bench
  input wire logic [1:0] int_n,
  input wire logic [3:0] gpio_src,
  input wire logic [1:0] cable_ok,
  // Link side
  output serializer_link_pkg::bc_frame_type [1:0] bc_frame,
  output logic [1:0] link_detect
);
  timeunit 1ns;
  timeprecision 1ps;
  import serializer_link_pkg::*;
  initial begin
    bc_frame = '0;
    link_detect = 2'b00;
  end
  // One good back-channel frame per port each pixel clock
  always @(negedge pix_clk) begin
    for (int p = 0; p < 2; p++) begin
      bc_frame[p].valid <= 1'b1;
      bc_frame[p].crc_ok <= 1'b1;
      bc_frame[p].remote_interrupt_in_n <= int_n[p];
      bc_frame[p].i2c <= 1'b1;
      bc_frame[p].gpio <= gpio_src;
    end
    link_detect <= cable_ok;
  end
endmodule : deser_model

/* File: tb/serializer_link_control_status_test.sv */
module serializer_link_control_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  import serializer_link_pkg::*;
  localparam logic [7:0] ADDRS [8] = '{FILTER_CFG_ADDR, GPIO0_CFG_ADDR,
    GPIO12_CFG_ADDR, GPIO3_CFG_ADDR, PORT_SEL_ADDR, LINK_MODE_ADDR,
    INT_ENABLE_ADDR, REM_ROUTE_ADDR};
  logic sys_clk, pix_clk, rst_n, power_down_n;
  reg_req_type reg_req;
  reg_resp_type reg_resp;
  video_in_type video_in;
  logic [1:0][34:0] fwd_frame;
  bc_frame_type [1:0] bc_frame;
  logic [1:0] link_detect, int_n, cable_ok;
  logic [3:0] gpio_in, gpio_out, gpio_oe, gpio_src;
  logic interrupt_out_n, remote_interrupt_out_n;
  logic [7:0] rv, vs;
  int fail_count, tests_run;
  serializer_link_control_status #(.FILTER_LEN(FILTER_MIN_PCLK)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .pix_clk(pix_clk),
    .power_down_n(power_down_n), .reg_req(reg_req), .reg_resp(reg_resp),
    .video_in(video_in), .fwd_frame(fwd_frame), .bc_frame(bc_frame),
    .link_detect(link_detect), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .interrupt_out_n(interrupt_out_n),
    .remote_interrupt_out_n(remote_interrupt_out_n));
  deser_model i_far (.pix_clk(pix_clk), .int_n(int_n), .gpio_src(gpio_src),
    .cable_ok(cable_ok), .bc_frame(bc_frame), .link_detect(link_detect));
  // Clocks
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    pix_clk = 1'b0;
    #37;
    forever #80 pix_clk = ~pix_clk;
  end
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [7:0] rst_val(input logic [7:0] a);
    case (a)
      FILTER_CFG_ADDR: return FILTER_CFG_RESET;
      PORT_SEL_ADDR: return PORT_SEL_RESET;
      LINK_MODE_ADDR: return LINK_MODE_RESET;
      default: return 8'h00;
    endcase
  endfunction : rst_val
  task automatic chk(input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic pins(input logic [7:0] exp);
    chk({6'h00, interrupt_out_n, remote_interrupt_out_n}, exp);
  endtask : pins
  task automatic pw(input int n);
    repeat (n) @(negedge pix_clk);
  endtask : pw
  task automatic wr(input logic [7:0] a, d, input logic sa);
    @(negedge sys_clk);
    reg_req = '{wr: 1'b1, rd: 1'b0, second_addr: sa, addr: a, wdata: d};
    @(negedge sys_clk);
    reg_req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic sa,
      output logic [8:0] r);
    @(negedge sys_clk);
    reg_req = '{wr: 1'b0, rd: 1'b1, second_addr: sa, addr: a, wdata: 8'h00};
    @(negedge sys_clk);
    reg_req.rd = 1'b0;
    r = {reg_resp.rvalid, reg_resp.rdata};
  endtask : rd
  task automatic rc(input logic [7:0] a, exp, input logic sa);
    logic [8:0] r;
    rd(a, sa, r);
    chk({7'h00, r[8]}, 8'h01);
    chk(r[7:0], exp);
  endtask : rc
  task automatic defaults();
    foreach (ADDRS[i]) begin
      rc(ADDRS[i], rst_val(ADDRS[i]), 1'b0);
    end
  endtask : defaults
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  // Random pixel data, control signals kept quiet
  always @(negedge pix_clk) begin
    vs <= lfsr(vs);
    video_in <= '{rgb: {3{vs}}, horizontal_sync: 1'b0, vertical_sync: 1'b0,
      data_enable: 1'b0, i2c: vs[0], audio: vs[2:0]};
    gpio_in <= vs[7:4];
  end
  initial begin
    #100us;
    fail_count++;
    close_out();
  end
  // Main sequence
  initial begin
    logic [8:0] r;
    fail_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    power_down_n = 1'b1;
    reg_req = '0;
    video_in = '0;
    int_n = 2'b11;
    gpio_src = 4'h0;
    cable_ok = 2'b11;
    gpio_in = 4'h0;
    rv = 8'h18;
    vs = 8'h18;
    repeat (2) @(negedge pix_clk);
    rst_n = 1'b1;
    repeat (200) @(negedge sys_clk);
    defaults();
    rc(8'h55, 8'h00, 1'b0);
    for (int i = 0; i < 6; i++) begin
      rv = lfsr(rv);
      wr(GPIO12_CFG_ADDR, rv, 1'b0);
      rc(GPIO12_CFG_ADDR, rv, 1'b0);
    end
    wr(LINK_MODE_ADDR, 8'h02, 1'b0);
    wr(PORT_SEL_ADDR, 8'h03, 1'b0);
    wr(GPIO0_CFG_ADDR, 8'h11, 1'b0);
    wr(PORT_SEL_ADDR, 8'h02, 1'b0);
    wr(GPIO0_CFG_ADDR, 8'h22, 1'b0);
    rc(FILTER_CFG_ADDR, FILTER_CFG_RESET, 1'b0);
    wr(PORT_SEL_ADDR, 8'h01, 1'b0);
    rc(GPIO0_CFG_ADDR, 8'h11, 1'b0);
    wr(PORT_SEL_ADDR, 8'h03, 1'b0);
    rc(GPIO0_CFG_ADDR, 8'h22, 1'b0);
    wr(PORT_SEL_ADDR, 8'h04, 1'b0);
    rc(GPIO0_CFG_ADDR, 8'h22, 1'b1);
    rc(GPIO0_CFG_ADDR, 8'h11, 1'b0);
    wr(GPIO0_CFG_ADDR, 8'h33, 1'b1);
    wr(PORT_SEL_ADDR, 8'h01, 1'b0);
    rd(GPIO0_CFG_ADDR, 1'b1, r);
    chk({7'h00, r[8]}, 8'h00);
    wr(LINK_MODE_ADDR, 8'h01, 1'b0);
    wr(PORT_SEL_ADDR, 8'h03, 1'b0);
    wr(GPIO0_CFG_ADDR, 8'h44, 1'b0);
    rc(GPIO0_CFG_ADDR, 8'h44, 1'b0);
    wr(LINK_MODE_ADDR, 8'h02, 1'b0);
    rc(GPIO0_CFG_ADDR, 8'h33, 1'b0);
    wr(LINK_MODE_ADDR, 8'h00, 1'b0);
    rc(PORT_SEL_ADDR, 8'h01, 1'b0);
    wr(PORT_SEL_ADDR, 8'h03, 1'b0);
    rc(PORT_SEL_ADDR, 8'h01, 1'b0);
    wr(LINK_MODE_ADDR, 8'h01, 1'b0);
    // Pin driven from the back channel, then released as a forward input
    wr(GPIO0_CFG_ADDR, {4'h0, GPIO_BC_OUTPUT}, 1'b0);
    gpio_src = 4'h1;
    pw(12);
    chk({6'h00, gpio_oe[0], gpio_out[0]}, 8'h03);
    gpio_src = 4'h0;
    pw(4);
    chk({6'h00, gpio_oe[0], gpio_out[0]}, 8'h02);
    wr(GPIO0_CFG_ADDR, {4'h0, GPIO_FWD_INPUT}, 1'b0);
    pw(12);
    chk({6'h00, gpio_oe[0], gpio_out[0]}, 8'h00);
    // Remote interrupt round trip
    wr(INT_ENABLE_ADDR, 8'h21, 1'b0);
    pw(12);
    int_n = 2'b10;
    pw(4);
    pins(8'h00);
    rc(INT_STATUS_ADDR, 8'h01, 1'b0);
    pins(8'h02);
    int_n = 2'b11;
    pw(4);
    pins(8'h03);
    rc(INT_STATUS_ADDR, 8'h00, 1'b0);
    int_n = 2'b01;
    pw(6);
    pins(8'h03);
    wr(LINK_MODE_ADDR, 8'h02, 1'b0);
    pw(12);
    pins(8'h00);
    rc(INT_STATUS_ADDR, 8'h01, 1'b0);
    wr(REM_ROUTE_ADDR, {4'h0, REM_ROUTE_SPLIT}, 1'b0);
    pw(12);
    pins(8'h03);
    int_n = 2'b11;
    pw(4);
    int_n = 2'b10;
    pw(6);
    pins(8'h02);
    int_n = 2'b11;
    cable_ok = 2'b10;
    pw(4);
    rd(STATUS_ADDR, 1'b0, r);
    chk({7'h00, r[LINK_DETECT_BIT]}, 8'h00);
    cable_ok = 2'b11;
    pw(4);
    rd(STATUS_ADDR, 1'b0, r);
    chk({7'h00, r[LINK_DETECT_BIT]}, 8'h01);
    power_down_n = 1'b0;
    repeat (2) @(negedge pix_clk);
    power_down_n = 1'b1;
    repeat (200) @(negedge sys_clk);
    defaults();
    pins(8'h03);
    close_out();
  end
endmodule : serializer_link_control_status_test
